// ### verilog/aac_cfg.svh
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

// Widths
`define AAC_DATA_W       8
`define AAC_ADDR_W       8
`define AAC_PC_W         13
// Bit positions used by the flag logic
`define AAC_MSB          7
`define AAC_NIB_MSB      3
`define AAC_NIB_W        4
// Reset values
`define AAC_ACC_RST      8'h00
`define AAC_PC_RST       13'h0000
`define AAC_ZERO_BYTE    8'h00
`define AAC_ZERO_NIB     5'h00
`define AAC_ZERO_BIT     1'h0
// Return address offset
`define AAC_PC_STEP      13'h0001

`endif

// ### verilog/aac_pkg.sv
package aac_pkg;

  // Operation select
  typedef enum logic [3:0] {
    AAC_OP_NONE,
    AAC_OP_ADC_ACC,
    AAC_OP_ADC_MEM,
    AAC_OP_ADD_ACC,
    AAC_OP_ADD_IMM,
    AAC_OP_ADD_MEM,
    AAC_OP_AND_ACC,
    AAC_OP_AND_IMM,
    AAC_OP_AND_MEM,
    AAC_OP_CALL
  } aac_op_t;

  // Status flags
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } aac_flags_t;

  // Instruction issued to the unit
  typedef struct packed {
    aac_op_t     op;
    logic [7:0]  imm;
    logic [7:0]  mem_addr;
    logic [12:0] target;
  } aac_instr_t;

  // Data memory write-back
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } aac_mem_wr_t;

  // Stack push
  typedef struct packed {
    logic        push;
    logic [12:0] ret_addr;
  } aac_push_t;

endpackage

// ### verilog/aac_adder.sv
`timescale 1ns/1ps
`include "aac_cfg.svh"

module aac_adder (
  input  wire logic [`AAC_DATA_W-1:0] a_in,     // First operand
  input  wire logic [`AAC_DATA_W-1:0] b_in,     // Second operand
  input  wire logic                   cin_in,   // Carry input
  output logic      [`AAC_DATA_W-1:0] sum_out,  // 8-bit sum
  output aac_pkg::aac_flags_t         flags_out // Flags of the sum
);

  wire logic [`AAC_NIB_W:0]  low_sum;
  wire logic [`AAC_DATA_W:0] full_sum;
  wire logic                 sign_ovf;

  assign low_sum  = {1'b0, a_in[`AAC_NIB_MSB:0]} + {1'b0, b_in[`AAC_NIB_MSB:0]}
                  + {{`AAC_NIB_W{`AAC_ZERO_BIT}}, cin_in};
  assign full_sum = {1'b0, a_in} + {1'b0, b_in} + {`AAC_ZERO_BYTE, cin_in};
  assign sign_ovf = (a_in[`AAC_MSB] == b_in[`AAC_MSB])
                  && (full_sum[`AAC_MSB] != a_in[`AAC_MSB]);

  assign sum_out                   = full_sum[`AAC_DATA_W-1:0];
  assign flags_out.overflow_flag   = sign_ovf;
  assign flags_out.zero_flag       = (full_sum[`AAC_DATA_W-1:0] == `AAC_ZERO_BYTE);
  assign flags_out.half_carry_flag = low_sum[`AAC_NIB_W];
  assign flags_out.carry_flag      = full_sum[`AAC_DATA_W];

endmodule

// ### verilog/aac_exec.sv
`timescale 1ns/1ps
`include "aac_cfg.svh"

// Notes on behaviour
// - Add-with-carry sums accumulator, memory operand and carry into the accumulator, all four flags updated.
// - Add-with-carry to memory writes the same sum back to the memory location, all four flags updated.
// - Plain add puts accumulator plus memory operand into the accumulator, all four flags updated.
// - Immediate add puts accumulator plus immediate byte into the accumulator, all four flags updated.
// - Plain add to memory writes accumulator plus operand back to memory, all four flags updated.
// - AND with memory operand goes to the accumulator and changes only the zero flag.
// - AND with the immediate byte goes to the accumulator and changes only the zero flag.
// - AND with memory operand goes back to memory and changes only the zero flag.
// - A call pushes program counter plus one and leaves every flag alone.
// - After the push the call loads the target into the program counter.
// - A call takes two instruction cycles.
module aac_exec (
  input  wire logic                   clock_in,     // Instruction clock
  input  wire logic                   sys_rst_in,   // Synchronous reset, active high
  input  wire logic                   issue_in,     // Instruction valid this cycle
  input  aac_pkg::aac_instr_t         instr_in,     // Decoded instruction
  input  wire logic [`AAC_DATA_W-1:0] mem_rdata_in, // Operand read from data memory
  input  aac_pkg::aac_flags_t         flags_in,     // Current status flags
  output logic                        ready_out,    // Can take an instruction
  output logic [`AAC_DATA_W-1:0]      accumulator_out, // Accumulator
  output logic [`AAC_PC_W-1:0]        pc_out,       // Program counter
  output aac_pkg::aac_flags_t         flags_out,    // Flags to store
  output logic                        flags_we_out, // Flag store strobe
  output aac_pkg::aac_mem_wr_t        mem_wr_out,   // Data memory write
  output aac_pkg::aac_push_t          push_out      // Stack push
);

  typedef enum logic {AAC_ST_RUN, AAC_ST_CALL2} aac_state_t;

  aac_state_t                 state;
  aac_state_t                 next_state;
  logic [`AAC_DATA_W-1:0]     accumulator;
  logic [`AAC_PC_W-1:0]       pc;
  logic [`AAC_PC_W-1:0]       call_target;
  aac_pkg::aac_flags_t        flags_q;
  logic                       flags_we;
  aac_pkg::aac_mem_wr_t       mem_wr;
  aac_pkg::aac_push_t         push;

  wire logic                  take;
  wire aac_pkg::aac_op_t      op;
  wire logic                  use_carry;
  wire logic                  use_imm;
  wire logic                  is_add;
  wire logic                  is_and;
  wire logic                  to_mem;
  wire logic                  is_call;
  wire logic [`AAC_DATA_W-1:0] operand_b;
  wire logic [`AAC_DATA_W-1:0] add_sum;
  wire aac_pkg::aac_flags_t   add_flags;
  wire logic [`AAC_DATA_W-1:0] and_res;
  wire logic [`AAC_DATA_W-1:0] result;
  wire aac_pkg::aac_flags_t   and_flags;
  wire aac_pkg::aac_flags_t   next_flags;
  wire logic [`AAC_PC_W-1:0]  next_pc;
  wire logic                  do_alu;
  wire logic                  do_call;
  wire logic                  acc_we;
  wire logic                  mem_we;
  wire logic                  in_call2;
  wire logic [`AAC_DATA_W-1:0] next_accumulator;
  wire logic [`AAC_PC_W-1:0]  next_pc_reg;
  wire logic [`AAC_PC_W-1:0]  next_call_target;

  assign take      = issue_in && (state == AAC_ST_RUN);
  assign op        = instr_in.op;
  assign use_carry = (op == aac_pkg::AAC_OP_ADC_ACC) || (op == aac_pkg::AAC_OP_ADC_MEM);
  assign use_imm   = (op == aac_pkg::AAC_OP_ADD_IMM) || (op == aac_pkg::AAC_OP_AND_IMM);
  assign is_add    = use_carry || (op == aac_pkg::AAC_OP_ADD_ACC)
                   || (op == aac_pkg::AAC_OP_ADD_IMM) || (op == aac_pkg::AAC_OP_ADD_MEM);
  assign is_and    = (op == aac_pkg::AAC_OP_AND_ACC) || (op == aac_pkg::AAC_OP_AND_IMM)
                   || (op == aac_pkg::AAC_OP_AND_MEM);
  assign to_mem    = (op == aac_pkg::AAC_OP_ADC_MEM) || (op == aac_pkg::AAC_OP_ADD_MEM)
                   || (op == aac_pkg::AAC_OP_AND_MEM);
  assign is_call   = (op == aac_pkg::AAC_OP_CALL);

  assign operand_b = use_imm ? instr_in.imm : mem_rdata_in;

  // Shared adder, carry in only for carry forms
  aac_adder u_adder (
    .a_in      (accumulator),
    .b_in      (operand_b),
    .cin_in    (use_carry & flags_in.carry_flag),
    .sum_out   (add_sum),
    .flags_out (add_flags)
  );

  assign and_res   = accumulator & operand_b;
  assign and_flags = '{overflow_flag:   flags_in.overflow_flag,
                       zero_flag:       (and_res == `AAC_ZERO_BYTE),
                       half_carry_flag: flags_in.half_carry_flag,
                       carry_flag:      flags_in.carry_flag};
  assign result     = is_add ? add_sum : and_res;
  assign next_flags = is_add ? add_flags : and_flags;

  // Return address is PC plus one
  assign next_pc = pc + `AAC_PC_STEP;

  assign do_alu   = take && (is_add || is_and);
  assign do_call  = take && is_call;
  assign in_call2 = (state == AAC_ST_CALL2);

  assign mem_we   = do_alu && to_mem;
  assign acc_we           = do_alu && !to_mem;
  assign next_accumulator = acc_we ? result : accumulator;

  assign next_pc_reg      = in_call2 ? call_target
                          : (take && !is_call) ? next_pc
                          : pc;
  assign next_call_target = do_call ? instr_in.target : call_target;

  always_comb begin
    next_state = state;
    unique case (state)
      AAC_ST_RUN: begin
        if (take && is_call) begin
          next_state = AAC_ST_CALL2;
        end
      end
      AAC_ST_CALL2: begin
        next_state = AAC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state <= AAC_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      accumulator <= `AAC_ACC_RST;
    end else begin
      accumulator <= next_accumulator;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pc <= `AAC_PC_RST;
    end else begin
      pc <= next_pc_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      call_target <= `AAC_PC_RST;
    end else begin
      call_target <= next_call_target;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      flags_q  <= '0;
      flags_we <= `AAC_ZERO_BIT;
    end else begin
      flags_q  <= next_flags;
      flags_we <= do_alu;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mem_wr <= '0;
    end else begin
      mem_wr.we   <= mem_we;
      mem_wr.addr <= instr_in.mem_addr;
      mem_wr.data <= result;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      push <= '0;
    end else begin
      push.push     <= do_call;
      push.ret_addr <= next_pc;
    end
  end

  // Busy during the call's second cycle
  assign ready_out       = (state == AAC_ST_RUN);
  assign accumulator_out = accumulator;
  assign pc_out          = pc;
  assign flags_out       = flags_q;
  assign flags_we_out    = flags_we;
  assign mem_wr_out      = mem_wr;
  assign push_out        = push;

endmodule

// ### bench/aac_exec_properties.sv
`timescale 1ns/1ps
module aac_exec_properties (
  input wire logic            clock_in, sys_rst_in, issue_in, ready_out, flags_we_out, // Control
  input wire logic [7:0]      mem_rdata_in, accumulator_out, // Data
  input wire logic [12:0]     pc_out,                         // Program counter
  input aac_pkg::aac_instr_t  instr_in,                       // Instruction
  input aac_pkg::aac_flags_t  flags_in, flags_out,            // Flags
  input aac_pkg::aac_mem_wr_t mem_wr_out,                     // Memory write
  input aac_pkg::aac_push_t   push_out                        // Stack push
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence take(aac_pkg::aac_op_t o);
    issue_in && ready_out && instr_in.op == o;
  endsequence
  call_push_a: assert property (take(aac_pkg::AAC_OP_CALL) |=> push_out.push && !ready_out
    && push_out.ret_addr == $past(pc_out) + 13'h0001) else $error("call push bad");
  call_jump_a: assert property (take(aac_pkg::AAC_OP_CALL) |=> ##1 ready_out
    && pc_out == $past(instr_in.target, 2)) else $error("call target bad");
  call_flags_a: assert property (take(aac_pkg::AAC_OP_CALL) |=> (!flags_we_out)[*2])
    else $error("call touched flags");
  adc_acc_a: assert property (take(aac_pkg::AAC_OP_ADC_ACC) |=> accumulator_out ==
    $past(accumulator_out) + $past(mem_rdata_in) + $past(flags_in.carry_flag)) else $error("adc bad");
  add_zero_a: assert property (take(aac_pkg::AAC_OP_ADD_ACC) |=> flags_we_out &&
    flags_out.zero_flag == (accumulator_out == 8'h00)) else $error("add zero bad");
  add_carry_a: assert property (take(aac_pkg::AAC_OP_ADD_IMM) |=> flags_out.carry_flag ==
    (accumulator_out < $past(accumulator_out))) else $error("add carry bad");
  add_to_mem_keep_a: assert property (take(aac_pkg::AAC_OP_ADD_MEM) |=> mem_wr_out.we &&
    mem_wr_out.addr == $past(instr_in.mem_addr) && accumulator_out == $past(accumulator_out))
    else $error("add to memory bad");
  bitand_to_mem_zero_a: assert property (take(aac_pkg::AAC_OP_AND_MEM) |=> mem_wr_out.data ==
    ($past(accumulator_out) & $past(mem_rdata_in)) && flags_out.zero_flag == (mem_wr_out.data == 8'h00))
    else $error("and to memory bad");
  and_imm_a: assert property (take(aac_pkg::AAC_OP_AND_IMM) |=> flags_we_out
    && flags_out.carry_flag == $past(flags_in.carry_flag) && flags_out.overflow_flag ==
    $past(flags_in.overflow_flag) && accumulator_out == ($past(accumulator_out) & $past(instr_in.imm)))
    else $error("and immediate bad");
endmodule
bind aac_exec aac_exec_properties props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .issue_in(issue_in), .ready_out(ready_out), .flags_we_out(flags_we_out), .pc_out(pc_out),
  .mem_rdata_in(mem_rdata_in), .accumulator_out(accumulator_out), .instr_in(instr_in),
  .flags_in(flags_in), .flags_out(flags_out), .mem_wr_out(mem_wr_out), .push_out(push_out));

// ### bench/accumulator_add_and_call_exec_bench.sv
`timescale 1ns/1ps
module accumulator_add_and_call_exec_bench;
  logic                 clock_in = 1'b0, sys_rst_in = 1'b1, issue_in = 1'b0;
  logic                 ready_out, flags_we_out;
  logic [7:0]           mem_rdata_in = 8'h00, accumulator_out, acc, r;
  logic [12:0]          pc_out, pc;
  logic [11:0]          s;
  aac_pkg::aac_instr_t  instr_in = '0;
  aac_pkg::aac_flags_t  flags_in = '0, flags_out, fx;
  aac_pkg::aac_mem_wr_t mem_wr_out;
  aac_pkg::aac_push_t   push_out;
  int                   n_fail = 0, checks_done = 0;
  always #12.5 clock_in = ~clock_in;
  aac_exec dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .issue_in(issue_in),
    .instr_in(instr_in), .mem_rdata_in(mem_rdata_in), .flags_in(flags_in), .ready_out(ready_out),
    .accumulator_out(accumulator_out), .pc_out(pc_out), .flags_out(flags_out),
    .flags_we_out(flags_we_out), .mem_wr_out(mem_wr_out), .push_out(push_out));
  // Sum with flags packed as overflow, zero, half carry, carry, sum
  function automatic logic [11:0] addf(logic [7:0] a, logic [7:0] b, logic c);
    logic [8:0] t;
    logic [4:0] h;
    t = a + b + c;
    h = a[3:0] + b[3:0] + c;
    return {a[7] == b[7] && t[7] != a[7], t[7:0] == 8'h00, h[4], t[8], t[7:0]};
  endfunction
  task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(aac_pkg::aac_op_t o, logic [7:0] v, logic [7:0] m, logic [12:0] t);
    logic imm, mem, lg, adc, nz;
    imm = o inside {aac_pkg::AAC_OP_ADD_IMM, aac_pkg::AAC_OP_AND_IMM};
    mem = o inside {aac_pkg::AAC_OP_ADC_MEM, aac_pkg::AAC_OP_ADD_MEM, aac_pkg::AAC_OP_AND_MEM};
    lg = o inside {aac_pkg::AAC_OP_AND_ACC, aac_pkg::AAC_OP_AND_IMM, aac_pkg::AAC_OP_AND_MEM};
    adc = o inside {aac_pkg::AAC_OP_ADC_ACC, aac_pkg::AAC_OP_ADC_MEM};
    nz = o != aac_pkg::AAC_OP_NONE;
    s = addf(acc, imm ? v : m, adc & flags_in.carry_flag);
    r = lg ? acc & (imm ? v : m) : s[7:0];
    fx = lg ? {flags_in.overflow_flag, r == 8'h00, flags_in[1:0]} : s[11:8];
    issue_in = 1'b1;
    instr_in = '{o, v, m ^ 8'h5A, t};
    mem_rdata_in = m;
    @(posedge clock_in);
    #2;
    if (o == aac_pkg::AAC_OP_CALL) begin
      chk("push", {push_out.push, ready_out, pc_out}, {2'b10, pc});
      chk("return", push_out.ret_addr, pc + 13'h0001);
      // Issue while busy must be ignored
      instr_in.op = aac_pkg::AAC_OP_AND_ACC;
      @(posedge clock_in);
      #2;
      pc = t;
      chk("jump", {ready_out, flags_we_out, pc_out, accumulator_out}, {2'b10, pc, acc});
    end else begin
      pc = pc + 13'h0001;
      acc = (mem || !nz) ? acc : r;
      chk("acc pc", {accumulator_out, pc_out}, {acc, pc});
      chk("mem", {mem_wr_out.we, mem ? mem_wr_out[15:0] : 16'h0}, {mem, mem ? {m ^ 8'h5A, r} : 16'h0});
      chk("flags", {flags_we_out, push_out.push, flags_out & {4{flags_we_out}}}, {nz, 1'b0, fx & {4{nz}}});
      if (nz)
        flags_in = fx;
    end
  endtask
  initial begin
    aac_pkg::aac_op_t ops[9] = '{aac_pkg::AAC_OP_AND_IMM, aac_pkg::AAC_OP_ADD_IMM,
      aac_pkg::AAC_OP_ADD_IMM, aac_pkg::AAC_OP_ADD_IMM, aac_pkg::AAC_OP_ADC_ACC, aac_pkg::AAC_OP_CALL,
      aac_pkg::AAC_OP_NONE, aac_pkg::AAC_OP_CALL, aac_pkg::AAC_OP_AND_MEM};
    logic [7:0] vals[9] = '{8'h00, 8'h7F, 8'h01, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF};
    acc = 8'h00;
    pc = 13'h0000;
    void'($urandom(32'h7F01));
    repeat (8) @(posedge clock_in);
    #2;
    sys_rst_in = 1'b0;
    // Overflow, half carry, carry and zero boundaries, then two calls with a no-op between them
    foreach (ops[i]) run(ops[i], vals[i], vals[i], 13'h1FFF);
    repeat (400) run(aac_pkg::aac_op_t'($urandom_range(9, 0)), 8'($urandom), 8'($urandom), 13'($urandom));
    complete_run();
  end
  initial begin
    #100us;
    n_fail++;
    complete_run();
  end
endmodule
